// ### prs_consts.svh
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Parameter numbers on the parameter access port
`define PRS_PAR_NUM_W 8
`define PRS_PAR_TEMP_LIMIT 8'h6e
`define PRS_PAR_MAINT_CMD 8'h71

// Temperature limit range and reset value, degrees Celsius
`define PRS_TEMP_MIN 16'h000a
`define PRS_TEMP_MAX 16'h0050
`define PRS_TEMP_RESET 16'h0050

// Maintenance command codes, 16-bit two's complement
`define PRS_CODE_RESET 16'hfffa
`define PRS_CODE_FACT_SAVE_MID 16'hfffb
`define PRS_CODE_USER_MID 16'hfffc
`define PRS_CODE_FACT_CLR_NET 16'hfffd
`define PRS_CODE_USER 16'hfffe
`define PRS_CODE_FACT 16'hffff
`define PRS_CODE_SAVE 16'h0001
`define PRS_CMD_RESET 16'h0000

`endif

// ### prs_pkg.sv
package prs_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_load,
    st_save,
    st_mid
  } prs_state_e;

  // Steps that one maintenance command asks for
  typedef struct packed {
    logic load_fact;
    logic load_user;
    logic clear_net;
    logic save_nv;
    logic mid_run;
  } prs_action_s;

endpackage : prs_pkg

// ### prs_temp_limit.sv
`timescale 1ns/10ps
`include "prs_consts.svh"

module prs_temp_limit
  import prs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic wr_ok,
  output logic [15:0] limit
);

  // Range check, out-of-range writes leave the value alone
  assign wr_ok = (wdata >= `PRS_TEMP_MIN) && (wdata <= `PRS_TEMP_MAX);

  // Retained limit register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      limit <= `PRS_TEMP_RESET;
    end else if (wr_en && wr_ok) begin
      limit <= wdata;
    end
  end

  temp_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (limit >= `PRS_TEMP_MIN) && (limit <= `PRS_TEMP_MAX))
    else $error("temperature limit outside range");
  temp_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_en && !wr_ok |=> $stable(limit))
    else $error("temperature limit changed by a refused write");

endmodule : prs_temp_limit

// ### prs_maint_cmd.sv
`timescale 1ns/10ps
`include "prs_consts.svh"

module prs_maint_cmd
  import prs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic par_req,
  input wire logic par_we,
  input wire logic [`PRS_PAR_NUM_W-1:0] par_num,
  input wire logic [15:0] par_wdata,
  input wire logic standstill,
  input wire logic [15:0] ctrl_word,
  input wire logic nv_done,
  input wire logic mid_done,
  output logic par_ack,
  output logic par_err,
  output logic [15:0] par_rdata,
  output logic [15:0] temp_limit,
  output logic full_reset,
  output logic load_fact,
  output logic load_user,
  output logic clear_net,
  output logic save_nv,
  output logic mid_start,
  output logic mid_abort,
  output logic ctrl_ignore,
  output logic run_inhibit
);

  // ****************************************
  // Access decode
  // ****************************************
  prs_state_e state;
  prs_state_e next_state;
  prs_action_s pend;
  prs_action_s dec_act;
  logic [15:0] cmd_value;
  logic [15:0] ctrl_ref;
  logic temp_ok;

  wire is_temp = (par_num == `PRS_PAR_TEMP_LIMIT);
  wire is_cmd = (par_num == `PRS_PAR_MAINT_CMD);
  wire wr = par_req && par_we;
  wire code_m6 = (par_wdata == `PRS_CODE_RESET);
  wire code_m5 = (par_wdata == `PRS_CODE_FACT_SAVE_MID);
  wire code_m4 = (par_wdata == `PRS_CODE_USER_MID);
  wire code_m3 = (par_wdata == `PRS_CODE_FACT_CLR_NET);
  wire code_m2 = (par_wdata == `PRS_CODE_USER);
  wire code_m1 = (par_wdata == `PRS_CODE_FACT);
  wire code_p1 = (par_wdata == `PRS_CODE_SAVE);
  wire code_valid = code_m6 | code_m5 | code_m4 | code_m3 | code_m2 | code_m1 | code_p1;
  // Save code 1 only at standstill, -5 and -3 save at any time; one command at a time, so a busy sequencer refuses
  wire code_ok = code_valid && (!code_p1 || standstill) && (state == st_idle);
  wire cmd_take = wr && is_cmd && code_ok;
  wire temp_take = wr && is_temp && temp_ok;
  wire req_ok = par_we ? (cmd_take || temp_take) : (is_temp || is_cmd);
  wire [15:0] next_rdata = is_temp ? temp_limit : (is_cmd ? cmd_value : 16'h0000);

  // Steps per code; network addressing only touched by -3
  assign dec_act.load_fact = code_m5 | code_m3 | code_m1;
  assign dec_act.load_user = code_m4 | code_m2;
  assign dec_act.clear_net = code_m3;
  assign dec_act.save_nv = code_m5 | code_m3 | code_p1;
  assign dec_act.mid_run = code_m5 | code_m4;

  prs_temp_limit u_temp (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_en(wr && is_temp),
    .wdata(par_wdata),
    .wr_ok(temp_ok),
    .limit(temp_limit)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Any difference from the word seen at run start counts as a new command
  wire ctrl_changed = (ctrl_word != ctrl_ref);

  // Order is load, then save, then mid-travel run
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (cmd_take && !code_m6) begin
          next_state = st_load;
        end
      end
      st_load: begin
        if (pend.save_nv) begin
          next_state = st_save;
        end else if (pend.mid_run) begin
          next_state = st_mid;
        end else begin
          next_state = st_idle;
        end
      end
      st_save: begin
        if (nv_done) begin
          next_state = pend.mid_run ? st_mid : st_idle;
        end
      end
      st_mid: begin
        if (ctrl_changed || mid_done) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  wire mid_enter = (next_state == st_mid) && (state != st_mid);
  wire next_abort = (state == st_mid) && ctrl_changed;
  // Stale control word must not replay its target once the run ends
  wire next_inhibit = ((state == st_mid) && mid_done && !ctrl_changed) || (run_inhibit && !ctrl_changed);

  // State and captured values
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      pend <= '0;
      cmd_value <= `PRS_CMD_RESET;
      ctrl_ref <= 16'h0000;
    end else begin
      state <= next_state;
      pend <= cmd_take ? dec_act : pend;
      cmd_value <= cmd_take ? par_wdata : cmd_value;
      ctrl_ref <= mid_enter ? ctrl_word : ctrl_ref;
    end
  end

  // Registered outputs, every action but ctrl_ignore and run_inhibit a one-cycle pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      par_ack <= 1'b0;
      par_err <= 1'b0;
      par_rdata <= 16'h0000;
      full_reset <= 1'b0;
      load_fact <= 1'b0;
      load_user <= 1'b0;
      clear_net <= 1'b0;
      save_nv <= 1'b0;
      mid_start <= 1'b0;
      mid_abort <= 1'b0;
      ctrl_ignore <= 1'b0;
      run_inhibit <= 1'b0;
    end else begin
      par_ack <= par_req && req_ok;
      par_err <= par_req && !req_ok;
      par_rdata <= next_rdata;
      full_reset <= cmd_take && code_m6;
      load_fact <= cmd_take && dec_act.load_fact;
      load_user <= cmd_take && dec_act.load_user;
      clear_net <= cmd_take && dec_act.clear_net;
      save_nv <= (state == st_load) && pend.save_nv;
      mid_start <= mid_enter;
      mid_abort <= next_abort;
      ctrl_ignore <= (next_state == st_mid);
      run_inhibit <= next_inhibit;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Waits on the store and the drive are open-ended, so each hand-off is checked edge to edge
  // rather than as one long sequence, which would need an unbounded repetition

  // Command sequences

  reset_pulse_a: assert property (cmd_take && code_m6 |=> full_reset && !load_fact && !save_nv)
    else $error("reset code did not give a lone reset pulse");
  fact_save_mid_a: assert property (cmd_take && code_m5 |=> load_fact && !save_nv ##1 save_nv && !mid_start)
    else $error("factory load and save out of order");
  save_mid_a: assert property ((state == st_save) && nv_done && pend.mid_run |=> mid_start && ctrl_ignore)
    else $error("mid run did not follow the save");
  save_lone_a: assert property (cmd_take && code_p1 |=> !load_fact && !load_user ##1 save_nv && !mid_start)
    else $error("save code did more than save");
  user_mid_a: assert property (cmd_take && code_m4 |=> load_user && !clear_net ##1 mid_start && !save_nv)
    else $error("user reload then mid run out of order");
  clear_net_a: assert property (cmd_take && code_m3 |=> clear_net && load_fact ##1 save_nv)
    else $error("network clear path wrong");
  user_nosave_a: assert property (cmd_take && code_m2 |=> load_user ##1 !save_nv && !mid_start ##1 state == st_idle)
    else $error("user reload wrote memory or ran");
  fact_nosave_a: assert property (cmd_take && code_m1 |=> load_fact && !clear_net ##1 !save_nv && !mid_start)
    else $error("factory load wrote memory or ran");
  save_still_a: assert property (wr && is_cmd && code_p1 && !standstill |=> par_err && !load_fact ##1 !save_nv)
    else $error("save accepted while moving");

  // Control word during and after the mid run
  mid_abort_a: assert property ((state == st_mid) && ctrl_changed |=> mid_abort && !ctrl_ignore && !run_inhibit)
    else $error("control word change did not abort mid run");
  no_resume_a: assert property ((state == st_mid) && mid_done && !ctrl_changed |=>
    run_inhibit && !ctrl_ignore && !mid_start)
    else $error("old run command not held off");
  inhibit_hold_a: assert property (run_inhibit && !ctrl_changed |=> run_inhibit)
    else $error("inhibit dropped with the old control word");
  inhibit_free_a: assert property (run_inhibit && ctrl_changed |=> !run_inhibit)
    else $error("inhibit kept after a new control word");

  // Access port answers
  bad_code_a: assert property (wr && is_cmd && !code_valid |=> par_err && !par_ack && $stable(cmd_value)
    && !full_reset && !load_fact && !load_user)
    else $error("invalid code acted upon");
  // A busy sequencer refuses new commands rather than queueing them
  busy_refuse_a: assert property (wr && is_cmd && (state != st_idle) |=> par_err && !par_ack && !load_fact
    && !load_user && !full_reset)
    else $error("command taken while busy");
  read_ack_a: assert property (par_req && !par_we && is_temp |=> par_ack && (par_rdata == temp_limit))
    else $error("limit read not answered");

endmodule : prs_maint_cmd

// ### prs_drive_model.sv
`timescale 1ns/10ps

// ********************************
// Drive and non-volatile store
// ********************************
module prs_drive_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic save_nv,
  input wire logic mid_start,
  input wire logic [7:0] lat,
  output logic nv_done,
  output logic mid_done
);
  logic [7:0] nv_cnt;
  logic [7:0] mid_cnt;

  // Completion pulse lat+2 cycles after each start pulse; the bench sets lat to make the drive prompt or slow
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nv_cnt <= 8'h00;
      mid_cnt <= 8'h00;
      nv_done <= 1'b0;
      mid_done <= 1'b0;
    end else begin
      nv_cnt <= save_nv ? lat + 8'h01 : nv_cnt - 8'((nv_cnt != 8'h00));
      mid_cnt <= mid_start ? lat + 8'h01 : mid_cnt - 8'((mid_cnt != 8'h00));
      nv_done <= (nv_cnt == 8'h01);
      mid_done <= (mid_cnt == 8'h01);
    end
  end
endmodule : prs_drive_model

// ### test_prs_maint_cmd.sv
`timescale 1ns/10ps
`include "prs_consts.svh"

// ********************************
// Bench for the maintenance commands
// ********************************
module test_prs_maint_cmd;
  logic sys_clk, nrst, par_req, par_we, standstill, nv_done, mid_done;
  logic [7:0] par_num, lat;
  logic [15:0] par_wdata, ctrl_word, par_rdata, temp_limit, rd;
  logic par_ack, par_err, full_reset, load_fact, load_user, clear_net;
  logic save_nv, mid_start, mid_abort, ctrl_ignore, run_inhibit;
  logic [5:0] p1, p2;
  int n_mismatch = 0;
  int check_count = 0;
  logic [15:0] codes [7] = '{16'hfffa, 16'hfffb, 16'hfffc, 16'hfffd, 16'hfffe, 16'hffff, 16'h0001};
  logic [5:0] exp1 [7] = '{6'h20, 6'h10, 6'h08, 6'h14, 6'h08, 6'h10, 6'h00};
  logic [5:0] exp2 [7] = '{6'h00, 6'h02, 6'h01, 6'h02, 6'h00, 6'h00, 6'h02};

  prs_maint_cmd i_prs_maint_cmd (.sys_clk(sys_clk), .nrst(nrst), .par_req(par_req), .par_we(par_we),
    .par_num(par_num), .par_wdata(par_wdata), .standstill(standstill), .ctrl_word(ctrl_word),
    .nv_done(nv_done), .mid_done(mid_done), .par_ack(par_ack), .par_err(par_err), .par_rdata(par_rdata),
    .temp_limit(temp_limit), .full_reset(full_reset), .load_fact(load_fact), .load_user(load_user),
    .clear_net(clear_net), .save_nv(save_nv), .mid_start(mid_start), .mid_abort(mid_abort),
    .ctrl_ignore(ctrl_ignore), .run_inhibit(run_inhibit));
  prs_drive_model i_prs_drive_model (.sys_clk(sys_clk), .nrst(nrst), .save_nv(save_nv),
    .mid_start(mid_start), .lat(lat), .nv_done(nv_done), .mid_done(mid_done));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // One access; answer and pulses sampled one and two edges after the request edge
  task automatic acc(input logic we, input logic [7:0] num, input logic [15:0] d, input logic ok);
    @(posedge sys_clk);
    par_req <= 1'b1;
    par_we <= we;
    par_num <= num;
    par_wdata <= d;
    @(posedge sys_clk);
    par_req <= 1'b0;
    @(posedge sys_clk);
    p1 = {full_reset, load_fact, load_user, clear_net, save_nv, mid_start};
    rd = par_rdata;
    chk("par_ack", {15'h0, ok}, {15'h0, par_ack});
    chk("par_err", {15'h0, !ok}, {15'h0, par_err});
    @(posedge sys_clk);
    p2 = {full_reset, load_fact, load_user, clear_net, save_nv, mid_start};
  endtask : acc

  // Limit range edges and read back
  task automatic t_temp();
    chk("temp_reset", `PRS_TEMP_RESET, temp_limit);
    acc(1'b0, `PRS_PAR_TEMP_LIMIT, 16'h0000, 1'b1);
    chk("temp_read", 16'h0050, rd);
    acc(1'b1, `PRS_PAR_TEMP_LIMIT, 16'h0009, 1'b0);
    acc(1'b1, `PRS_PAR_TEMP_LIMIT, 16'h0051, 1'b0);
    chk("temp_kept", 16'h0050, temp_limit);
    acc(1'b1, `PRS_PAR_TEMP_LIMIT, 16'h000a, 1'b1);
    chk("temp_min", 16'h000a, temp_limit);
    acc(1'b1, `PRS_PAR_TEMP_LIMIT, 16'h0050, 1'b1);
    chk("temp_max", 16'h0050, temp_limit);
  endtask : t_temp

  // Bad codes and numbers; code 1 away from standstill
  task automatic t_reject();
    standstill <= 1'b0;
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'h0001, 1'b0);
    chk("save_moving", 16'h0000, {10'h0, p2});
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'h0000, 1'b0);
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'h0002, 1'b0);
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'hfff9, 1'b0);
    chk("bad_code", 16'h0000, {10'h0, p1 | p2});
    acc(1'b1, 8'h70, 16'hffff, 1'b0);
  endtask : t_reject

  // Every command code with its pulse pattern
  task automatic t_codes();
    standstill <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, `PRS_PAR_MAINT_CMD, codes[i], 1'b1);
      chk("pulses_c1", {10'h0, exp1[i]}, {10'h0, p1});
      chk("pulses_c2", {10'h0, exp2[i]}, {10'h0, p2});
      repeat (16) @(posedge sys_clk);
    end
    acc(1'b0, `PRS_PAR_MAINT_CMD, 16'h0000, 1'b1);
    chk("cmd_read", 16'h0001, rd);
  endtask : t_codes

  // Unchanged control word after mid run, then a change releases the inhibit
  task automatic t_inhibit();
    chk("inhibit", 16'h0001, {15'h0, run_inhibit});
    chk("ignore_off", 16'h0000, {15'h0, ctrl_ignore});
    ctrl_word <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    chk("inhibit_clr", 16'h0000, {15'h0, run_inhibit});
  endtask : t_inhibit

  // Slow mid run aborted by a control word change
  task automatic t_abort();
    lat <= 8'h30;
    ctrl_word <= 16'h0014;
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'hfffc, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk("ignore_on", 16'h0001, {15'h0, ctrl_ignore});
    chk("no_abort", 16'h0000, {15'h0, mid_abort});
    acc(1'b1, `PRS_PAR_MAINT_CMD, 16'hffff, 1'b0);
    chk("busy_refuse", 16'h0000, {10'h0, p1 | p2});
    ctrl_word <= 16'h0015;
    repeat (2) @(posedge sys_clk);
    chk("abort", 16'h0001, {15'h0, mid_abort});
    @(posedge sys_clk);
    chk("ignore_drop", 16'h0000, {15'h0, ctrl_ignore | run_inhibit});
    repeat (60) @(posedge sys_clk);
  endtask : t_abort

  // Time-zero values, reset, scenarios
  initial begin
    nrst = 1'b0;
    par_req = 1'b0;
    par_we = 1'b0;
    par_num = 8'h00;
    par_wdata = 16'h0000;
    standstill = 1'b1;
    ctrl_word = 16'h0014;
    lat = 8'h02;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_temp();
    t_reject();
    t_codes();
    t_inhibit();
    t_abort();
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
endmodule : test_prs_maint_cmd
